// ### rtl/power_mode_map.vh
// Constants for the low-power mode controller: register offsets, fields, reset values, timing.
// Assumes an APB master with 32-bit data and one aligned word per register.
//
// Overview of operation
// - Sleep stops CPU, clocks and peripherals run
// - Medium sleep clocks peripherals at selected divide
// - CPU registers retained throughout sleep
// - Enabled interrupt ends sleep, starts exception
// - Mask bit or disabled source keeps sleep
// - Sleep returns to the matching active speed
// - Reset pin low ends sleep into reset
// - Interrupts synchronised, up to two clocks late
// - Medium sleep may start half state early
// - Standby stops the system oscillator
// - Standby retains state, ports high impedance
// - Standby wake restarts oscillator, waits, then handles
// - Standby exit speed chosen by medium enable
// - Mask bit or disabled source keeps standby
// - Subactive-to-active: sub clock, then wait states
// - Reset sets interrupt mask, other flags kept; reset input clears them to 0
`ifndef POWER_MODE_MAP_VH
`define POWER_MODE_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_SYSTEM_CONTROL_ONE 12'h000
`define OFS_SYSTEM_CONTROL_TWO 12'h004
`define OFS_CONDITION_CODE     12'h008
`define OFS_MODE_STATUS        12'h00c
`define OFS_COMMAND            12'h010

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define SC1_MA_LO     0
`define SC1_MA_HI     1
`define SC1_STS_LO    4
`define SC1_STS_HI    6
`define SC1_STANDBY   7
`define SC2_MEDIUM_SPEED_ENABLE      0
`define SC2_DTON      1
`define CCR_IMASK     7
`define CMD_SLEEP     0
`define CMD_MASK_SET  1
`define CMD_MASK_CLR  2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SC1_RESET     8'h00
`define SC2_RESET     8'h00

// ----------------------------------------------------------------
// Mode codes reported in status
// ----------------------------------------------------------------
`define MODE_RESET    4'h0
`define MODE_ACTIVE   4'h1
`define MODE_SLEEP    4'h2
`define MODE_STDBY    4'h3
`define MODE_OSCWAIT  4'h4
`define MODE_EXCEPT   4'h5
`define MODE_SUBACT   4'h6
`define MODE_TRANS    4'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SLEEP_INSN_STATES   4'd2
`define INTERNAL_STATES     4'd1
`define EXCEPTION_STATES    5'd14
`define SUBCLK_DIV          8'd8
`define WAIT_W              16

`endif

// ### rtl/low_power_mode_control.v
// Low-power mode controller: sleep, standby, subactive transitions, wake by interrupt.
// Assumes irq_req, irq_en, external_reset_pin_n and osc_stable come from outside the clock domain.
`timescale 1ns/1ps
`include "power_mode_map.vh"

module low_power_mode_control (
    input  wire        ref_clk,
    input  wire        reset,
    input  wire        external_reset_pin_n,
    input  wire [7:0]  irq_req,
    input  wire [7:0]  irq_en,
    input  wire        osc_stable,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    output reg         cpu_run,
    output reg         sys_osc_en,
    output reg         sub_osc_en,
    output reg         periph_clk_en,
    output reg  [1:0]  periph_div_sel,
    output reg         ports_hiz,
    output reg         exception_start,
    output reg         cpu_reset
);

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam [3:0] S_RESET   = 4'd0;
    localparam [3:0] S_ACTIVE  = 4'd1;
    localparam [3:0] S_SLEEP   = 4'd2;
    localparam [3:0] S_STDBY   = 4'd3;
    localparam [3:0] S_OSCWAIT = 4'd4;
    localparam [3:0] S_EXCEPT  = 4'd5;
    localparam [3:0] S_SUBACT  = 4'd6;
    localparam [3:0] S_TRANS   = 4'd7;

    // Wait selection in system clock states
    function [`WAIT_W-1:0] wait_states;
        input [2:0] sel;
        begin
            case (sel)
                3'd0:    wait_states = 16'd8192;
                3'd1:    wait_states = 16'd16384;
                3'd2:    wait_states = 16'd1024;
                3'd3:    wait_states = 16'd2048;
                3'd4:    wait_states = 16'd4096;
                3'd5:    wait_states = 16'd2;
                3'd6:    wait_states = 16'd8;
                default: wait_states = 16'd16;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    reg  [17:0] sync1_q;
    reg  [17:0] sync2_q;
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync1_q <= 18'h00000;
            sync2_q <= 18'h00000;
        end else begin
            sync1_q <= {osc_stable, ~external_reset_pin_n, irq_en, irq_req};
            sync2_q <= sync1_q;
        end
    end
    wire [7:0] req_s    = sync2_q[7:0];
    wire [7:0] en_s     = sync2_q[15:8];
    wire       pin_rst  = sync2_q[16];
    wire       stable_s = sync2_q[17];

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [7:0]  sc1_q;
    reg  [7:0]  sc2_q;
    reg  [7:0]  ccr_q;
    reg  [3:0]  state_q;
    reg  [3:0]  state_d;
    reg  [`WAIT_W-1:0] cnt_q;
    reg  [`WAIT_W-1:0] cnt_d;
    reg  [7:0]  sub_div_q;
    reg         target_sub_q;
    reg         target_sub_d;

    wire wr = psel & penable & pwrite;
    wire cmd_wr = wr & (paddr == `OFS_COMMAND);
    wire sleep_cmd = cmd_wr & pwdata[`CMD_SLEEP];
    wire wake = |(req_s & en_s) & ~ccr_q[`CCR_IMASK];

    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sc1_q <= `SC1_RESET;
            sc2_q <= `SC2_RESET;
            ccr_q <= 8'h80;
        end else begin
            if (state_q == S_RESET) begin
                ccr_q[`CCR_IMASK] <= 1'b1;
            end else if (cmd_wr & pwdata[`CMD_MASK_SET]) begin
                ccr_q[`CCR_IMASK] <= 1'b1;
            end else if (cmd_wr & pwdata[`CMD_MASK_CLR]) begin
                ccr_q[`CCR_IMASK] <= 1'b0;
            end else if (wr & (paddr == `OFS_CONDITION_CODE)) begin
                ccr_q <= pwdata[7:0];
            end
            if (wr & (paddr == `OFS_SYSTEM_CONTROL_ONE)) begin
                sc1_q <= pwdata[7:0];
            end
            if (wr & (paddr == `OFS_SYSTEM_CONTROL_TWO)) begin
                sc2_q <= pwdata[7:0];
            end
        end
    end

    always @* begin
        case (paddr)
            `OFS_SYSTEM_CONTROL_ONE: prdata = {24'h000000, sc1_q};
            `OFS_SYSTEM_CONTROL_TWO: prdata = {24'h000000, sc2_q};
            `OFS_CONDITION_CODE:     prdata = {24'h000000, ccr_q};
            `OFS_MODE_STATUS:        prdata = {27'h0000000, target_sub_q, state_q};
            default:                 prdata = 32'h00000000;
        endcase
    end

    // ----------------------------------------------------------------
    // Mode sequencer
    // ----------------------------------------------------------------
    // Subclock state tick: subactive logic advances once per SUBCLK_DIV cycles
    wire sub_tick = (sub_div_q == `SUBCLK_DIV - 8'd1);
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sub_div_q <= 8'h00;
        end else begin
            sub_div_q <= sub_tick ? 8'h00 : sub_div_q + 8'd1;
        end
    end

    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        target_sub_d = target_sub_q;
        case (state_q)
            S_RESET: begin
                state_d = S_ACTIVE;
                target_sub_d = 1'b0;
            end
            S_ACTIVE: begin
                if (sleep_cmd & pwdata[`SC1_STANDBY] & pwdata[`CMD_SLEEP] & sc1_q[`SC1_STANDBY]) begin
                    state_d = S_STDBY;
                end else if (sleep_cmd & sc2_q[`SC2_DTON]) begin
                    state_d = S_TRANS;
                    cnt_d = {12'h000, `SLEEP_INSN_STATES + `INTERNAL_STATES};
                    target_sub_d = 1'b1;
                end else if (sleep_cmd & sc1_q[`SC1_STANDBY]) begin
                    state_d = S_STDBY;
                end else if (sleep_cmd) begin
                    state_d = S_SLEEP;
                end
            end
            S_SLEEP: begin
                if (wake) begin
                    state_d = S_EXCEPT;
                    cnt_d = {11'h000, `EXCEPTION_STATES};
                end
            end
            S_STDBY: begin
                if (wake) begin
                    state_d = S_OSCWAIT;
                end
            end
            S_OSCWAIT: begin
                // Counter loads only once the oscillator reports running
                if (stable_s & (cnt_q == 16'h0000)) begin
                    cnt_d = wait_states(sc1_q[`SC1_STS_HI:`SC1_STS_LO]);
                end else if (cnt_q == 16'h0001) begin
                    state_d = S_EXCEPT;
                    cnt_d = {11'h000, `EXCEPTION_STATES};
                end else if (cnt_q != 16'h0000) begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            S_EXCEPT: begin
                if (~target_sub_q | sub_tick) begin
                    cnt_d = cnt_q - 16'h0001;
                    if (cnt_q == 16'h0001) begin
                        state_d = target_sub_q ? S_SUBACT : S_ACTIVE;
                    end
                end
            end
            S_SUBACT: begin
                if (sleep_cmd) begin
                    state_d = S_TRANS;
                    cnt_d = {12'h000, `SLEEP_INSN_STATES + `INTERNAL_STATES};
                    target_sub_d = 1'b0;
                end
            end
            S_TRANS: begin
                // Leaving subactive counts sleep states on subclock ticks; leaving active on system clock
                if (target_sub_q | sub_tick) begin
                    cnt_d = cnt_q - 16'h0001;
                    if (cnt_q == 16'h0001) begin
                        cnt_d = 16'h0000;
                        state_d = target_sub_q ? S_EXCEPT : S_OSCWAIT;
                        if (target_sub_q) begin
                            cnt_d = {11'h000, `EXCEPTION_STATES};
                        end
                    end
                end
            end
            default: state_d = S_RESET;
        endcase
    end

    // ----------------------------------------------------------------
    // Effective next state
    // ----------------------------------------------------------------
    // The pin reset overrides the sequencer, so the output
    // registers must follow the same choice as the state
    // register. Otherwise cpu_reset would rise one cycle
    // before ports_hiz and the outputs would disagree for a
    // cycle on every pin reset.
    reg  [3:0]  next_state;
    always @* begin
        next_state = state_d;
        if (pin_rst) begin
            next_state = S_RESET;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // The pin reset is a level: the block stays in the reset
    // state for as long as the synchronised pin is low, so a
    // host that holds the pin until the oscillator settles
    // sees no activity before then.
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q <= S_RESET;
            cnt_q <= 16'h0000;
            target_sub_q <= 1'b0;
        end else if (pin_rst) begin
            state_q <= S_RESET;
            cnt_q <= 16'h0000;
            target_sub_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            target_sub_q <= target_sub_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cpu_run <= 1'b0;
            sys_osc_en <= 1'b1;
            sub_osc_en <= 1'b1;
            periph_clk_en <= 1'b0;
            periph_div_sel <= 2'b00;
            ports_hiz <= 1'b1;
            exception_start <= 1'b0;
            cpu_reset <= 1'b1;
        end else begin
            // CPU gated, not reset, while asleep so its registers hold
            cpu_run <= (next_state == S_ACTIVE) | (next_state == S_SUBACT) | (next_state == S_EXCEPT);
            sys_osc_en <= (next_state != S_STDBY) & (next_state != S_SUBACT);
            sub_osc_en <= 1'b1;
            periph_clk_en <= (next_state != S_STDBY) & (next_state != S_OSCWAIT) & (next_state != S_RESET);
            // Medium speed applies whenever enabled, in every state
            periph_div_sel <= sc2_q[`SC2_MEDIUM_SPEED_ENABLE] ? {sc1_q[`SC1_MA_HI], sc1_q[`SC1_MA_LO]} : 2'b00;
            ports_hiz <= (next_state == S_STDBY) | (next_state == S_OSCWAIT) | (next_state == S_RESET);
            // One-cycle pulse on entry, so a long exception is not restarted
            exception_start <= (next_state == S_EXCEPT) & (state_q != S_EXCEPT);
            cpu_reset <= (next_state == S_RESET);
        end
    end

endmodule

// ### verification/irq_osc_model.sv
// Far-side model: interrupt sources and the restartable system oscillator.
// Assumes the bench drives fire with the wanted request levels.
`timescale 1ns/1ps
module irq_osc_model (
    input  wire       ref_clk,
    input  wire       reset,
    input  wire       sys_osc_en,
    input  wire [7:0] fire,
    output reg  [7:0] irq_req,
    output wire       osc_stable
);
    reg [2:0] warm_q;
    // ----
    // Requests and oscillator warm-up
    // ----
    // Requests stay up until the bench drops them, never self-clear
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq_req <= 8'h00;
            warm_q  <= 3'h0;
        end else begin
            irq_req <= fire;
            if (!sys_osc_en)
                warm_q <= 3'h0;
            else if (warm_q != 3'h7)
                warm_q <= warm_q + 3'h1;
        end
    end
    assign osc_stable = (warm_q == 3'h7);
endmodule

// ### verification/power_mode_properties.sv
// Port checker for the low-power mode controller.
// Assumes the bench uses standby wait selection 5 (two states).
`timescale 1ns/1ps
module power_mode_properties (
    input wire ref_clk,
    input wire reset,
    input wire external_reset_pin_n,
    input wire osc_stable,
    input wire cpu_run,
    input wire sub_osc_en,
    input wire periph_clk_en,
    input wire ports_hiz,
    input wire exception_start,
    input wire cpu_reset
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ----
    // Sequences and properties
    // ----
    sequence runs_on;
        cpu_run [*8];
    endsequence
    sequence osc_back;
        $rose(osc_stable) && ports_hiz && !cpu_reset;
    endsequence
    sub_osc_kept_a: assert property (sub_osc_en) else $error("subclock stopped");
    periph_off_hiz_a: assert property (!periph_clk_en |-> ports_hiz) else $error("ports driven");
    standby_stops_a: assert property (ports_hiz && !cpu_reset |-> !periph_clk_en && !cpu_run)
        else $error("standby still running");
    reset_state_a: assert property (cpu_reset |-> !cpu_run && ports_hiz) else $error("reset runs");
    pin_reset_a: assert property ($fell(external_reset_pin_n) |-> ##[1:4] cpu_reset)
        else $error("pin reset ignored");
    except_pulse_a: assert property (exception_start |=> !exception_start) else $error("long pulse");
    except_runs_a: assert property (exception_start |-> ##[0:2] runs_on) else $error("cpu idle");
    standby_wake_a: assert property (osc_back |-> ##[2:40] exception_start)
        else $error("standby wait wrong");
endmodule
bind low_power_mode_control power_mode_properties i_props (.ref_clk(ref_clk), .reset(reset),
    .external_reset_pin_n(external_reset_pin_n), .osc_stable(osc_stable), .cpu_run(cpu_run),
    .sub_osc_en(sub_osc_en), .periph_clk_en(periph_clk_en), .ports_hiz(ports_hiz),
    .exception_start(exception_start), .cpu_reset(cpu_reset));

// ### verification/tb.sv
// Self-checking bench for the low-power mode controller over APB.
// Assumes zero-wait APB and the partner model for requests and oscillator.
`timescale 1ns/1ps
`include "power_mode_map.vh"
module tb;
    reg         ref_clk, reset, external_reset_pin_n, psel, penable, pwrite;
    reg  [7:0]  fire, irq_en;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd;
    wire [31:0] prdata;
    wire [7:0]  irq_req;
    wire [1:0]  periph_div_sel;
    wire        pready, pslverr, cpu_run, sys_osc_en, sub_osc_en, periph_clk_en;
    wire        ports_hiz, exception_start, cpu_reset, osc_stable;
    integer     fail_count, samples_checked, n;
    low_power_mode_control i_dut (.ref_clk(ref_clk), .reset(reset),
        .external_reset_pin_n(external_reset_pin_n), .irq_req(irq_req), .irq_en(irq_en),
        .osc_stable(osc_stable), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .cpu_run(cpu_run),
        .sys_osc_en(sys_osc_en), .sub_osc_en(sub_osc_en), .periph_clk_en(periph_clk_en),
        .periph_div_sel(periph_div_sel), .ports_hiz(ports_hiz), .exception_start(exception_start),
        .cpu_reset(cpu_reset));
    irq_osc_model i_far (.ref_clk(ref_clk), .reset(reset), .sys_osc_en(sys_osc_en), .fire(fire),
        .irq_req(irq_req), .osc_stable(osc_stable));
    // ----
    // Tasks
    // ----
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            psel   <= 1'b1;
            pwrite <= w;
            paddr  <= a;
            pwdata <= d;
            @(posedge ref_clk);
            penable <= 1'b1;
            @(posedge ref_clk);
            while (pready !== 1'b1)
                @(posedge ref_clk);
            rd = prdata;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("BAD %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wait_exc(input integer lim);
        begin
            n = 0;
            while (exception_start !== 1'b1 && n < lim) begin
                @(posedge ref_clk);
                n = n + 1;
            end
        end
    endtask
    task idle(input integer c);
        repeat (c) @(posedge ref_clk);
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    // ----
    // Clock, watchdog and tests
    // ----
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        idle(20000);
        fail_count = fail_count + 1;
        test_done;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, fire, irq_en} = 0;
        reset = 1'b1;
        external_reset_pin_n = 1'b1;
        fail_count = 0;
        samples_checked = 0;
        idle(10);
        reset <= 1'b0;
        idle(1);
        apb(0, `OFS_CONDITION_CODE, 0);
        chk(rd[7], 1);
        apb(0, 12'h020, 0);
        chk(rd, 0);
        // Medium sleep, held first by the mask, then by a disabled source
        apb(1, `OFS_SYSTEM_CONTROL_ONE, 32'h2);
        apb(1, `OFS_SYSTEM_CONTROL_TWO, 32'h1);
        apb(1, `OFS_COMMAND, 32'h1);
        irq_en <= 8'hfb;
        fire <= 8'h04;
        idle(30);
        chk({cpu_run, sys_osc_en, periph_clk_en, periph_div_sel}, 5'b01110);
        apb(1, `OFS_COMMAND, 32'h4);
        idle(30);
        apb(0, `OFS_MODE_STATUS, 0);
        chk(rd[3:0], `MODE_SLEEP);
        irq_en <= 8'hff;
        wait_exc(8);
        chk(n < 8, 1);
        fire <= 8'h00;
        idle(20);
        apb(0, `OFS_MODE_STATUS, 0);
        chk({rd[3:0], periph_div_sel}, {`MODE_ACTIVE, 2'b10});
        // Standby with wait selection 5, mask set first
        apb(1, `OFS_SYSTEM_CONTROL_TWO, 32'h0);
        apb(1, `OFS_SYSTEM_CONTROL_ONE, 32'hd0);
        apb(1, `OFS_COMMAND, 32'h2);
        apb(1, `OFS_COMMAND, 32'h1);
        fire <= 8'h01;
        idle(40);
        chk({sys_osc_en, ports_hiz, cpu_run}, 3'b010);
        apb(1, `OFS_COMMAND, 32'h4);
        wait_exc(60);
        chk(n < 60, 1);
        fire <= 8'h00;
        idle(20);
        apb(0, `OFS_MODE_STATUS, 0);
        chk({rd[3:0], periph_div_sel}, {`MODE_ACTIVE, 2'b00});
        // Pin reset out of sleep; pin held well past oscillator settling
        apb(1, `OFS_SYSTEM_CONTROL_ONE, 32'h0);
        apb(1, `OFS_COMMAND, 32'h1);
        external_reset_pin_n <= 1'b0;
        idle(12);
        chk(cpu_reset, 1);
        external_reset_pin_n <= 1'b1;
        idle(8);
        apb(0, `OFS_CONDITION_CODE, 0);
        chk(rd[7], 1);
        // Direct transition into subactive
        apb(1, `OFS_COMMAND, 32'h4);
        apb(1, `OFS_SYSTEM_CONTROL_TWO, 32'h2);
        apb(1, `OFS_COMMAND, 32'h1);
        n = 0;
        do begin
            apb(0, `OFS_MODE_STATUS, 0);
            n = n + 3;
        end while (rd[3:0] !== `MODE_SUBACT && n < 900);
        chk({rd[3:0], cpu_run, sys_osc_en}, {`MODE_SUBACT, 2'b10});
        chk(n >= 14 * 8, 1);
        // Direct transition back to active, short wait selection
        apb(1, `OFS_SYSTEM_CONTROL_ONE, 32'h50);
        apb(1, `OFS_COMMAND, 32'h1);
        wait_exc(300);
        chk(n < 300, 1);
        idle(20);
        apb(0, `OFS_MODE_STATUS, 0);
        chk({rd[3:0], cpu_run, sys_osc_en}, {`MODE_ACTIVE, 2'b11});
        test_done;
    end
endmodule
